// ===== flr_defs.svh
`ifndef FLR_DEFS_SVH
`define FLR_DEFS_SVH

`define FLR_CLK_NS      10
`define FLR_HOLD0_NS    4000
`define FLR_HOLD1_NS    71000
`define FLR_HOLD2_NS    833000
`define FLR_HOLD3_NS    8000000
`define FLR_TEST_HZ     1000

`define FLR_CTRL_OFS    4'h0
`define FLR_STAT_OFS    4'h4

`define FLR_CTRL_SPLIT  0
`define FLR_CTRL_REPEAT 1
`define FLR_CTRL_INVERT 2
`define FLR_CTRL_HOLD   3
`define FLR_CTRL_TEST   5
`define FLR_CTRL_RST    6'h00

`endif

// ===== flr_pkg.sv
package flr_pkg;

  typedef enum logic [1:0] {
    FLR_IDLE     = 2'h0,
    FLR_OPT_SRC  = 2'h1,
    FLR_ELEC_SRC = 2'h2
  } flr_dir_e;

  typedef struct packed {
    logic       test_mode;
    logic [1:0] hold_sel;
    logic       invert;
    logic       retransmit_on_setting;
    logic       split_pair_setting;
  } flr_cfg_s;

  typedef struct packed {
    logic [1:0] dir;
    logic       wire_drive;
    logic       tx_wire_led;
    logic       tx_fiber_led;
    logic       rx_optical_led;
    logic       rx_electrical_led;
  } flr_stat_s;

endpackage

// ===== flr_repeater.sv
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`include "flr_defs.svh"

module flr_repeater #(
  parameter int HOLD1_CYC     = (`FLR_HOLD1_NS + `FLR_CLK_NS - 1) /
                                `FLR_CLK_NS,
  parameter int HOLD2_CYC     = (`FLR_HOLD2_NS + `FLR_CLK_NS - 1) /
                                `FLR_CLK_NS,
  parameter int HOLD3_CYC     = (`FLR_HOLD3_NS + `FLR_CLK_NS - 1) /
                                `FLR_CLK_NS,
  parameter int TEST_HALF_CYC = 1000000000 /
                                (2 * `FLR_TEST_HZ * `FLR_CLK_NS)
)(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        elec_rx_i,
  output logic             elec_tx_o,
  output logic             elec_tx_oe_o,
  input  wire logic        opt_rx_i,
  output logic             opt_tx_o,
  input  wire logic        repeat_en_i,
  input  wire logic        optical_en_i,
  output logic             rx_electrical_led_o,
  output logic             rx_optical_led_o,
  output logic             tx_fiber_led_o,
  output logic             tx_wire_led_o
);

  // Wire-side data: '1' is the active level, '0' the biased idle level.
  // Light on the fibre stands for '1', so an idle link leaves it dark.
  // No clock line exists on either side; any clock must ride in the data.

  localparam int CW        = 24;
  localparam int HOLD0_CYC = (`FLR_HOLD0_NS + `FLR_CLK_NS - 1) /
                             `FLR_CLK_NS;

  generate
    if (HOLD1_CYC < 1 || HOLD2_CYC < 1 || HOLD3_CYC < 1 ||
        HOLD3_CYC >= (1 << CW))
    begin : g_bad_hold
      $error("Holdover counts out of range");
    end
    if (HOLD0_CYC < 1 || HOLD0_CYC >= (1 << CW))
    begin : g_bad_hold0
      $error("Default holdover count out of range");
    end
    if (TEST_HALF_CYC < 1 || TEST_HALF_CYC >= (1 << CW))
    begin : g_bad_test
      $error("Test half period out of range");
    end
  endgenerate

  // Config and bus
  flr_pkg::flr_cfg_s  cfg_q;
  flr_pkg::flr_cfg_s  cfg_d;
  logic               wait_q;
  logic               wait_d;
  logic [31:0]        rdata_q;
  logic [31:0]        rdata_d;

  // Direction and counters
  flr_pkg::flr_dir_e  dir_q;
  flr_pkg::flr_dir_e  dir_d;
  logic [CW-1:0]      drv_cnt_q;
  logic [CW-1:0]      drv_cnt_d;
  logic [CW-1:0]      dir_cnt_q;
  logic [CW-1:0]      dir_cnt_d;
  logic [CW-1:0]      sq_cnt_q;
  logic [CW-1:0]      sq_cnt_d;
  logic               sq_q;
  logic               sq_d;

  // Pin outputs
  logic               elec_tx_q;
  logic               elec_tx_d;
  logic               elec_oe_q;
  logic               elec_oe_d;
  logic               opt_tx_q;
  logic               opt_tx_d;
  logic               led_re_q;
  logic               led_re_d;
  logic               led_ro_q;
  logic               led_ro_d;
  logic               led_to_q;
  logic               led_to_d;
  logic               led_te_q;
  logic               led_te_d;

  logic               e_in;
  logic               o_in;
  logic               opt2elec;
  logic               elec2opt;
  logic               od;
  logic               rep_on;
  flr_pkg::flr_stat_s stat;

  function automatic logic [CW-1:0] hold_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    hold_cycles = CW'(HOLD0_CYC);
      2'h1:    hold_cycles = CW'(HOLD1_CYC);
      2'h2:    hold_cycles = CW'(HOLD2_CYC);
      default: hold_cycles = CW'(HOLD3_CYC);
    endcase
  endfunction

  // Address decode, shared by the read and the write path
  function automatic logic is_ctrl(input logic [3:0] addr);
    is_ctrl = (addr == `FLR_CTRL_OFS);
  endfunction

  function automatic logic is_stat(input logic [3:0] addr);
    is_stat = (addr == `FLR_STAT_OFS);
  endfunction

  // ---------------- Register bus ----------------
  // Every access waits exactly one cycle, so the answer is fixed and
  // the slave needs no pipelining.
  always_comb
  begin
    wait_d  = ~((avs_read_i | avs_write_i) & wait_q);
    rdata_d = rdata_q;
    cfg_d   = cfg_q;
    if (avs_read_i && wait_q)
    begin
      // Unmapped reads answer zero, so probing never stalls the bus
      if (is_ctrl(avs_address_i))
      begin
        rdata_d = 32'(cfg_q);
      end
      else if (is_stat(avs_address_i))
      begin
        rdata_d = 32'(stat);
      end
      else
      begin
        rdata_d = 32'h0;
      end
    end
    if (avs_write_i && !wait_q && avs_byteenable_i[0] &&
        is_ctrl(avs_address_i))
    begin
      // Field by field, so the layout follows the position macros
      cfg_d.split_pair_setting    = avs_writedata_i[`FLR_CTRL_SPLIT];
      cfg_d.retransmit_on_setting = avs_writedata_i[`FLR_CTRL_REPEAT];
      cfg_d.invert                = avs_writedata_i[`FLR_CTRL_INVERT];
      cfg_d.hold_sel              = avs_writedata_i[`FLR_CTRL_HOLD +: 2];
      cfg_d.test_mode             = avs_writedata_i[`FLR_CTRL_TEST];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0;
      cfg_q   <= flr_pkg::flr_cfg_s'(`FLR_CTRL_RST);
    end
    else
    begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      cfg_q   <= cfg_d;
    end
  end

  // Live snapshot; nothing in it clears on read
  always_comb
  begin
    stat.dir               = dir_q;
    stat.wire_drive        = elec_oe_q;
    stat.tx_wire_led       = led_te_q;
    stat.tx_fiber_led      = led_to_q;
    stat.rx_optical_led    = led_ro_q;
    stat.rx_electrical_led = led_re_q;
  end

  // ---------------- Routing ----------------
  always_comb
  begin
    e_in   = elec_rx_i ^ cfg_q.invert;
    o_in   = opt_rx_i;
    rep_on = cfg_q.retransmit_on_setting & repeat_en_i;
  end

  // Direction is tracked on the shared pair; on the split pair it drops to idle, from FLR_ELEC_SRC once the wire input falls.
  always_comb
  begin
    dir_d     = dir_q;
    dir_cnt_d = (dir_cnt_q != '0) ? dir_cnt_q - CW'(1) : dir_cnt_q;
    case (dir_q)
      flr_pkg::FLR_IDLE:
      begin
        // Fibre wins a tie; the wire will retry once the link is idle
        if (!cfg_q.split_pair_setting && o_in)
          dir_d = flr_pkg::FLR_OPT_SRC;
        else if (!cfg_q.split_pair_setting && e_in)
        begin
          dir_d     = flr_pkg::FLR_ELEC_SRC;
          dir_cnt_d = hold_cycles(cfg_q.hold_sel);
        end
      end
      flr_pkg::FLR_OPT_SRC:
      begin
        // Wire is ours until the driver lets go, so its echo is ignored
        if (cfg_q.split_pair_setting ||
            (!o_in && drv_cnt_q == '0 && !elec_oe_q))
          dir_d = flr_pkg::FLR_IDLE;
      end
      flr_pkg::FLR_ELEC_SRC:
      begin
        if (e_in)
          dir_cnt_d = hold_cycles(cfg_q.hold_sel);
        else if (cfg_q.split_pair_setting || dir_cnt_q == '0)
          dir_d = flr_pkg::FLR_IDLE;
      end
      default:
        dir_d = flr_pkg::FLR_IDLE;
    endcase
  end

  always_comb
  begin
    opt2elec = cfg_q.split_pair_setting ||
               dir_d == flr_pkg::FLR_OPT_SRC;
    elec2opt = cfg_q.split_pair_setting ||
               dir_d == flr_pkg::FLR_ELEC_SRC;
    od       = o_in & opt2elec;
  end

  // ---------------- Wire driver ----------------
  always_comb
  begin
    drv_cnt_d = '0;
    elec_oe_d = 1'b0;
    elec_tx_d = cfg_q.invert;
    if (cfg_q.test_mode && cfg_q.split_pair_setting)
    begin
      elec_oe_d = 1'b1;
      elec_tx_d = elec_rx_i;
    end
    else if (od)
    begin
      // Ones are driven for as long as they last
      elec_oe_d = 1'b1;
      elec_tx_d = 1'b1 ^ cfg_q.invert;
      drv_cnt_d = hold_cycles(cfg_q.hold_sel);
    end
    else if (drv_cnt_q != '0 && opt2elec)
    begin
      // Too long a holdover will collide with the next sender on a bus
      elec_oe_d = 1'b1;
      elec_tx_d = 1'b0 ^ cfg_q.invert;
      drv_cnt_d = drv_cnt_q - CW'(1);
    end
  end

  // ---------------- Optical transmitter ----------------
  always_comb
  begin
    sq_cnt_d = '0;
    sq_d     = 1'b0;
    if (cfg_q.test_mode)
    begin
      if (sq_cnt_q == CW'(TEST_HALF_CYC - 1))
      begin
        sq_d = ~sq_q;
      end
      else
      begin
        sq_cnt_d = sq_cnt_q + CW'(1);
        sq_d     = sq_q;
      end
    end
    if (!optical_en_i)
      opt_tx_d = 1'b0;
    else if (cfg_q.test_mode)
      opt_tx_d = sq_d;
    else
      opt_tx_d = (e_in & elec2opt) |
                 (od & rep_on);
  end

  // ---------------- Indicators ----------------
  // Lights follow the registered paths, so they never lead the data
  always_comb
  begin
    led_re_d = od & ~(cfg_q.test_mode & cfg_q.split_pair_setting);
    led_ro_d = o_in;
    led_to_d = opt_tx_d;
    led_te_d = e_in & elec2opt & ~cfg_q.test_mode;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      dir_q     <= flr_pkg::FLR_IDLE;
      dir_cnt_q <= '0;
      drv_cnt_q <= '0;
      sq_cnt_q  <= '0;
      sq_q      <= 1'b0;
      elec_tx_q <= 1'b0;
      elec_oe_q <= 1'b0;
      opt_tx_q  <= 1'b0;
      led_re_q  <= 1'b0;
      led_ro_q  <= 1'b0;
      led_to_q  <= 1'b0;
      led_te_q  <= 1'b0;
    end
    else
    begin
      dir_q     <= dir_d;
      dir_cnt_q <= dir_cnt_d;
      drv_cnt_q <= drv_cnt_d;
      sq_cnt_q  <= sq_cnt_d;
      sq_q      <= sq_d;
      elec_tx_q <= elec_tx_d;
      elec_oe_q <= elec_oe_d;
      opt_tx_q  <= opt_tx_d;
      led_re_q  <= led_re_d;
      led_ro_q  <= led_ro_d;
      led_to_q  <= led_to_d;
      led_te_q  <= led_te_d;
    end
  end

  assign avs_readdata_o      = rdata_q;
  assign avs_waitrequest_o   = wait_q;
  assign elec_tx_o           = elec_tx_q;
  assign elec_tx_oe_o        = elec_oe_q;
  assign opt_tx_o            = opt_tx_q;
  assign rx_electrical_led_o = led_re_q;
  assign rx_optical_led_o    = led_ro_q;
  assign tx_fiber_led_o      = led_to_q;
  assign tx_wire_led_o       = led_te_q;

endmodule

// ===== flr_repeater_properties.sv
`timescale 1ns/10ps
module flr_repeater_properties (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic opt_rx_i,
  input wire logic opt_tx_o,
  input wire logic optical_en_i,
  input wire logic elec_tx_o,
  input wire logic elec_tx_oe_o,
  input wire logic rx_electrical_led_o,
  input wire logic rx_optical_led_o,
  input wire logic tx_fiber_led_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  property p_ack;
    s_req |=> s_ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus access not answered in one cycle");
  property p_wait_pulse;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse)
    else $error("waitrequest low for more than one cycle");
  property p_opt_led;
    !$past(reset_i) |-> rx_optical_led_o == $past(opt_rx_i);
  endproperty
  a_opt_led: assert property (p_opt_led)
    else $error("optical receive light does not follow receiver");
  property p_fiber_led;
    tx_fiber_led_o == opt_tx_o;
  endproperty
  a_fiber_led: assert property (p_fiber_led)
    else $error("optical transmit light differs from emitter");
  property p_dark;
    !optical_en_i |=> !opt_tx_o;
  endproperty
  a_dark: assert property (p_dark)
    else $error("emitter lit while optical output disabled");
  property p_elec_led;
    rx_electrical_led_o |-> elec_tx_oe_o;
  endproperty
  a_elec_led: assert property (p_elec_led)
    else $error("wire receive light without wire driver");
  property p_oe_hold;
    $rose(elec_tx_oe_o) |=> elec_tx_oe_o [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("wire driver released too early");
  // Every burst ends on the idle level, whichever inversion is set
  property p_flip;
    rx_electrical_led_o && !opt_rx_i |=>
      elec_tx_oe_o && elec_tx_o != $past(elec_tx_o);
  endproperty
  a_flip: assert property (p_flip)
    else $error("wire data did not follow optical edge");
endmodule

// ===== flr_field_model.sv
`timescale 1ns/10ps
module flr_field_model (
  input  wire logic split_i,
  input  wire logic oe_i,
  input  wire logic tx_i,
  input  wire logic drv_i,
  input  wire logic bit_i,
  input  wire logic bias_i,
  input  wire logic light_i,
  output logic      elec_rx_o,
  output logic      opt_rx_o
);
  // Undriven pair settles at the bias level, never the last bit
  always_comb
  begin
    if (!split_i && oe_i)
      elec_rx_o = tx_i;
    else if (drv_i)
      elec_rx_o = bit_i;
    else
      elec_rx_o = bias_i;
  end
  // Fibre receiver follows light_i as driven; no remote unit returns light
  assign opt_rx_o = light_i;
endmodule

// ===== flr_repeater_tb_top.sv
`timescale 1ns/10ps
module flr_repeater_tb_top;
  logic        clk_i, reset_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [3:0]  avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic        elec_rx_i, elec_tx_o, elec_tx_oe_o, opt_rx_i, opt_tx_o;
  logic        repeat_en_i, optical_en_i, rx_electrical_led_o;
  logic        rx_optical_led_o, tx_fiber_led_o, tx_wire_led_o;
  logic        split, drv, wbit, bias, light, prev;
  int          bad_count, total_checks, n;
  int          hv[4] = '{400, 20, 40, 80};

  flr_repeater #(.HOLD1_CYC(20), .HOLD2_CYC(40), .HOLD3_CYC(80),
    .TEST_HALF_CYC(16)) DUT (.clk_i, .reset_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .elec_rx_i, .elec_tx_o,
    .elec_tx_oe_o, .opt_rx_i, .opt_tx_o, .repeat_en_i, .optical_en_i,
    .rx_electrical_led_o, .rx_optical_led_o, .tx_fiber_led_o,
    .tx_wire_led_o);
  flr_field_model u_far (.split_i(split), .oe_i(elec_tx_oe_o),
    .tx_i(elec_tx_o), .drv_i(drv), .bit_i(wbit), .bias_i(bias),
    .light_i(light), .elec_rx_o(elec_rx_i), .opt_rx_o(opt_rx_i));

  task check(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task tick(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (avs_waitrequest_o !== 1'b0 && k < 20);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    check("bus wait", k < 20, 1);
    if (k >= 20)
      give_verdict();
  endtask
  task ctrl(input logic [5:0] v);
    split <= v[0];
    bus(1'b1, 4'h0, {26'h0, v});
  endtask
  // Burst of light, then time the driver holdover
  task hold(input int h, input logic inv, input logic otx);
    light <= 1'b1;
    tick(3);
    check("wire data", elec_tx_o, !inv);
    check("wire led", rx_electrical_led_o, 1);
    check("light led", rx_optical_led_o, 1);
    check("fibre out", opt_tx_o, otx);
    light <= 1'b0;
    n = 0;
    do
    begin
      tick(1);
      n++;
    end
    while (elec_tx_oe_o === 1'b1 && n < h + 9);
    check("holdover", n >= h && n <= h + 4, 1);
    check("wire led off", rx_electrical_led_o, 0);
  endtask

  initial
  begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end

  initial
  begin
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    {split, drv, wbit, bias, light} = '0;
    avs_byteenable_i = 4'hf;
    repeat_en_i = 1;
    optical_en_i = 1;
    reset_i = 1;
    tick(20);
    reset_i <= 0;
    bus(1'b1, 4'h4, 32'hff);
    bus(1'b1, 4'h8, 32'h3f);
    bus(1'b0, 4'h8, 0);
    check("unmapped", rd, 0);
    bus(1'b0, 4'h0, 0);
    check("ctrl", rd, 0);
    bus(1'b0, 4'h4, 0);
    check("status", rd, 0);
    $display("test registers done");
    for (int s = 0; s < 4; s++)
    begin
      ctrl({1'b0, s[1:0], 3'h0});
      hold(hv[s], 0, 0);
    end
    $display("test holdover done");
    ctrl(6'h02);
    hold(400, 0, 1);
    check("fibre led", tx_fiber_led_o, 0);
    repeat_en_i <= 0;
    hold(400, 0, 0);
    repeat_en_i <= 1;
    optical_en_i <= 0;
    hold(400, 0, 0);
    optical_en_i <= 1;
    $display("test repeat done");
    bias <= 1;
    ctrl(6'h05);
    drv <= 1;
    light <= 1;
    tick(3);
    check("dup fibre", opt_tx_o, 1);
    check("dup wire", elec_tx_o, 0);
    check("wire tx led", tx_wire_led_o, 1);
    {drv, light} <= 2'b00;
    tick(3);
    check("inv idle", opt_tx_o, 0);
    tick(410);
    $display("test split invert done");
    bias <= 0;
    ctrl(6'h00);
    {drv, wbit} <= 2'b11;
    tick(3);
    check("wire to fibre", opt_tx_o, 1);
    light <= 1;
    tick(3);
    check("no drive back", elec_tx_oe_o, 0);
    bus(1'b0, 4'h4, 0);
    check("direction", rd[6:5], 2'h2);
    {drv, light} <= 2'b00;
    tick(420);
    hold(400, 0, 0);
    $display("test shared pair done");
    ctrl(6'h21);
    drv <= 1;
    tick(3);
    check("loop one", elec_tx_o, 1);
    wbit <= 0;
    tick(3);
    check("loop zero", elec_tx_o, 0);
    prev = opt_tx_o;
    tick(16);
    check("square", opt_tx_o, !prev);
    drv <= 0;
    ctrl(6'h20);
    tick(3);
    check("no loop shared", elec_tx_oe_o, 0);
    prev = opt_tx_o;
    tick(16);
    check("square shared", opt_tx_o, !prev);
    ctrl(6'h00);
    $display("test loopback done");
    give_verdict();
  end
endmodule

bind flr_repeater flr_repeater_properties u_chk (.clk_i, .reset_i,
  .avs_read_i, .avs_write_i, .avs_waitrequest_o, .opt_rx_i, .opt_tx_o,
  .optical_en_i, .elec_tx_o, .elec_tx_oe_o, .rx_electrical_led_o,
  .rx_optical_led_o, .tx_fiber_led_o);
